/* File: lut_cfg.svh */
// Register indices, field positions, codes and reset values of the logic cell array
`ifndef LUT_CFG_SVH
`define LUT_CFG_SVH
`define REG_COUNT        24
`define REG_RESET        8'h00
`define IDX_CTRL_A       6'h00
`define IDX_SEQ_CTRL0    6'h01
`define IDX_SEQ_CTRL1    6'h02
`define IDX_RSVD_A       6'h03
`define IDX_RSVD_B       6'h04
`define IDX_IRQ_CTRL     6'h05
`define IDX_RSVD_C       6'h06
`define IDX_IRQ_FLAGS    6'h07
`define IDX_TBL_BASE     8
`define TBL_STRIDE       4
`define TBL_CTL_A        0
`define TBL_CTL_B        1
`define TBL_CTL_C        2
`define TBL_TRUTH        3
`define CTRLA_ENABLE_BIT 0
`define CTRLA_RUNSTBY_BIT 6
`define TA_ENABLE_BIT    0
`define TA_TABLE_CLOCK_SOURCE_LSB    1
`define TA_FILT_LSB      4
`define TA_EDGE_BIT      7
`define TABLE_CLOCK_SOURCE_ALT       3'h1
`define FILT_OFF         2'h0
`define FILT_SYNC        2'h1
`define FILT_FILTER      2'h2
`define SEQ_DISABLE      4'h0
`define SEQ_DFF          4'h1
`define SEQ_JK           4'h2
`define SEQ_GATED_D_LATCH_MODE       4'h3
`define SEQ_RS           4'h4
`define SENSE_OFF        2'h0
`define SENSE_RISE       2'h1
`define SENSE_FALL       2'h2
`define SENSE_BOTH       2'h3
`define INSEL_MASK       4'h0
`define INSEL_FEEDBACK   4'h1
`define INSEL_LINK       4'h2
`define INSEL_EVENT_A    4'h3
`define INSEL_EVENT_B    4'h4
`define INSEL_PIN        4'h5
`define INSEL_AC0        4'h6
`define INSEL_USART      4'h8
`define INSEL_SPI        4'h9
`define INSEL_TCA        4'hA
`define INSEL_TCB        4'hC
`endif

/* File: lut_pkg.sv */
// Types shared by the logic cell array
`default_nettype none
`include "lut_cfg.svh"
package lut_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic       ac0;
    logic [1:0] usart_txd;
    logic       spi_mosi;
    logic       spi_sck;
    logic [2:0] tca_wo;
    logic [1:0] tcb_wo;
  } periph_in_t;
  typedef struct packed {
    logic [`REG_COUNT-1:0][7:0] regs;
    logic [3:0][2:0]            pin_s1;
    logic [3:0][2:0]            pin_s2;
    logic [3:0]                 clk_s1;
    logic [3:0]                 clk_s2;
    logic [3:0]                 clk_s3;
    logic [1:0]                 seq_ff;
    logic [3:0]                 out_ff;
    logic                       irq_ff;
    logic                       pready_ff;
    logic                       pslverr_ff;
    logic [31:0]                prdata_ff;
  } core_state_t;
  typedef struct packed {
    logic [2:0] q;
    logic       filt;
    logic       prev;
  } post_state_t;
endpackage
`default_nettype wire

/* File: table_post.sv */
// Output synchronizer, glitch filter and rising-edge detector of one table
`default_nettype none
`include "lut_cfg.svh"
module table_post (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic       edge_en,
  input  wire logic [1:0] filt_sel,
  input  wire logic       raw,
  output logic            post
);
  lut_pkg::post_state_t st_ff;
  lut_pkg::post_state_t nxt_st;
  logic                 stage;

  always_comb begin
    nxt_st = st_ff;
    if (filt_sel == `FILT_SYNC) begin
      stage = st_ff.q[1];
    end else if (filt_sel == `FILT_FILTER) begin
      stage = st_ff.filt;
    end else begin
      stage = raw;
    end
    if (!enable) begin
      nxt_st = '0;
    end else if (tick) begin
      nxt_st.q = {st_ff.q[1:0], raw};
      if (st_ff.q[2] == st_ff.q[1] && st_ff.q[1] == st_ff.q[0]) begin
        nxt_st.filt = st_ff.q[2];
      end
      nxt_st.prev = stage;
    end
    post = edge_en ? (stage & ~st_ff.prev) : stage;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_clear;
    @(posedge core_clk) disable iff (reset)
    !enable |=> (st_ff == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("filter state not cleared");

  property p_filter;
    @(posedge core_clk) disable iff (reset)
    (enable && tick && st_ff.q == 3'h7) |=> st_ff.filt;
  endproperty
  a_filter: assert property (p_filter) else $error("stable high not passed");
endmodule // table_post
`default_nettype wire

/* File: custom_logic_unit.sv */
// Four-table programmable logic cell array with sequencers, APB registers
// Contract
// - Three independent input selects per table
// - Feedback input takes pair sequencer output
// - Link input takes next table, wraps
// - Events reach tables directly, two per table
// - Sync option delays output two edges
// - Filter passes stable values, four-edge lag
// - Disabled table clears filter state
// - Edge detector pulses on rising edge
// - Disabled table clears edge detector state
// - Sequencer uses even table clock, select field
// - D and JK sequencers update on edge, latches do not; cleared when disabled
// - D flip-flop: gate loads, else holds
// - JK: hold, clear, set, toggle
// - D latch transparent while gate high
// - RS latch: hold, clear, set
// - Peripheral clock default, alternate selectable
// - Alternate clock is input 2, masked low
// - Flag set on selected output edge
// - Request while any flag set, ORed
// - Standby without run forces clocked outputs low
// - Idle sleep keeps truth decoding running
// - Output is truth bit at input index
// - Sequencer select encoding
// - Interrupt sense encoding
// - Writing one clears a flag
`default_nettype none
`include "lut_cfg.svh"
module custom_logic_unit (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire lut_pkg::apb_req_t   apb_req,
  output var  lut_pkg::apb_rsp_t   apb_rsp,
  input  wire logic [3:0]          event_a,
  input  wire logic [3:0]          event_b,
  input  wire logic [3:0][2:0]     pin_in,
  input  wire lut_pkg::periph_in_t periph_in,
  input  wire logic                standby_sleep,
  output logic [3:0]               table_out,
  output logic                     irq
);
  lut_pkg::core_state_t st_ff;
  lut_pkg::core_state_t nxt_st;
  logic [3:0][2:0]      in_raw;
  logic [3:0][1:0]      filt;
  logic [3:0]           edge_en;
  logic [3:0]           truth_out;
  logic [3:0]           tick;
  logic [3:0]           enab;
  logic [3:0]           alt_sel;
  logic [3:0]           post;
  logic                 stop;

  // ==========================================================
  // Input selection and truth decoding
  always_comb begin
    logic [7:0] ca;
    logic [7:0] cb;
    logic [7:0] cc;
    logic [3:0] code;
    logic [2:0] tidx;
    int         base;
    ca = '0;
    cb = '0;
    cc = '0;
    code = '0;
    tidx = '0;
    base = 0;
    stop = standby_sleep & ~st_ff.regs[`IDX_CTRL_A][`CTRLA_RUNSTBY_BIT];
    in_raw = '0;
    for (int t = 0; t < 4; t++) begin
      base = `IDX_TBL_BASE + t * `TBL_STRIDE;
      ca = st_ff.regs[base + `TBL_CTL_A];
      cb = st_ff.regs[base + `TBL_CTL_B];
      cc = st_ff.regs[base + `TBL_CTL_C];
      for (int y = 0; y < 3; y++) begin
        if (y == 0) begin
          code = cb[3:0];
        end else if (y == 1) begin
          code = cb[7:4];
        end else begin
          code = cc[3:0];
        end
        case (code)
          `INSEL_FEEDBACK: in_raw[t][y] = st_ff.seq_ff[t / 2];
          `INSEL_LINK:     in_raw[t][y] = st_ff.out_ff[(t + 1) % 4];
          `INSEL_EVENT_A:  in_raw[t][y] = event_a[t];
          `INSEL_EVENT_B:  in_raw[t][y] = event_b[t];
          `INSEL_PIN:      in_raw[t][y] = st_ff.pin_s2[t][y];
          `INSEL_AC0:      in_raw[t][y] = periph_in.ac0;
          `INSEL_USART:    in_raw[t][y] = (y < 2) ? periph_in.usart_txd[y[0]] : 1'b0;
          `INSEL_SPI:      in_raw[t][y] = (y < 2) ? periph_in.spi_mosi : periph_in.spi_sck;
          `INSEL_TCA:      in_raw[t][y] = periph_in.tca_wo[y];
          `INSEL_TCB:      in_raw[t][y] = (y < 2) ? periph_in.tcb_wo[y[0]] : 1'b0;
          default:         in_raw[t][y] = 1'b0;
        endcase
      end
      alt_sel[t] = (ca[`TA_TABLE_CLOCK_SOURCE_LSB +: 3] == `TABLE_CLOCK_SOURCE_ALT);
      // Decoder is never gated by sleep state
      tidx = {in_raw[t][2] & ~alt_sel[t], in_raw[t][1], in_raw[t][0]};
      truth_out[t] = st_ff.regs[base + `TBL_TRUTH][tidx];
      tick[t] = alt_sel[t] ? (st_ff.clk_s2[t] & ~st_ff.clk_s3[t]) : ~stop;
      enab[t] = st_ff.regs[`IDX_CTRL_A][`CTRLA_ENABLE_BIT] & ca[`TA_ENABLE_BIT];
      filt[t] = ca[`TA_FILT_LSB +: 2];
      edge_en[t] = ca[`TA_EDGE_BIT];
    end
  end

  // ==========================================================
  // Per-table filter and edge detector
  for (genvar g = 0; g < 4; g++) begin : g_tbl
    table_post u_post (
      .core_clk (core_clk),
      .reset    (reset),
      .enable   (enab[g]),
      .tick     (tick[g]),
      .edge_en  (edge_en[g]),
      .filt_sel (filt[g]),
      .raw      (truth_out[g]),
      .post     (post[g])
    );
  end

  // ==========================================================
  // Sequencers, outputs, flags and register port
  always_comb begin
    logic [3:0] ssel;
    logic [3:0] set;
    logic [1:0] mode;
    logic [5:0] idx;
    logic       j;
    logic       k;
    logic       v;
    logic       fin;
    logic       uses;
    logic       ok;
    logic       access;
    ssel = '0;
    set = '0;
    mode = '0;
    j = 1'b0;
    k = 1'b0;
    v = 1'b0;
    fin = 1'b0;
    uses = 1'b0;
    idx = '0;
    ok = 1'b0;
    access = 1'b0;
    nxt_st = st_ff;
    nxt_st.pin_s1 = pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;
    nxt_st.clk_s1 = {in_raw[3][2], in_raw[2][2], in_raw[1][2], in_raw[0][2]};
    nxt_st.clk_s2 = st_ff.clk_s1;
    nxt_st.clk_s3 = st_ff.clk_s2;
    for (int p = 0; p < 2; p++) begin
      ssel = st_ff.regs[`IDX_SEQ_CTRL0 + p][3:0];
      j = post[2 * p];
      k = post[2 * p + 1];
      if (!enab[2 * p] || ssel == `SEQ_DISABLE) begin
        nxt_st.seq_ff[p] = 1'b0;
      end else begin
        case (ssel)
          `SEQ_DFF: begin
            if (tick[2 * p] && k) begin
              nxt_st.seq_ff[p] = j;
            end
          end
          `SEQ_JK: begin
            if (tick[2 * p]) begin
              case ({j, k})
                2'b01:   nxt_st.seq_ff[p] = 1'b0;
                2'b10:   nxt_st.seq_ff[p] = 1'b1;
                2'b11:   nxt_st.seq_ff[p] = ~st_ff.seq_ff[p];
                default: nxt_st.seq_ff[p] = st_ff.seq_ff[p];
              endcase
            end
          end
          `SEQ_GATED_D_LATCH_MODE: begin
            if (k) begin
              nxt_st.seq_ff[p] = j;
            end
          end
          `SEQ_RS: begin
            if (j && !k) begin
              nxt_st.seq_ff[p] = 1'b1;
            end else if (k && !j) begin
              nxt_st.seq_ff[p] = 1'b0;
            end
          end
          default: nxt_st.seq_ff[p] = 1'b0;
        endcase
      end
    end
    for (int t = 0; t < 4; t++) begin
      ssel = st_ff.regs[`IDX_SEQ_CTRL0 + t / 2][3:0];
      uses = (filt[t] != `FILT_OFF) | edge_en[t] | (ssel != `SEQ_DISABLE);
      v = (t % 2 == 0 && ssel != `SEQ_DISABLE) ? st_ff.seq_ff[t / 2] : post[t];
      fin = enab[t] & v & ~(stop & uses);
      nxt_st.out_ff[t] = fin;
      mode = st_ff.regs[`IDX_IRQ_CTRL][2 * t +: 2];
      case (mode)
        `SENSE_RISE: set[t] = fin & ~st_ff.out_ff[t];
        `SENSE_FALL: set[t] = ~fin & st_ff.out_ff[t];
        `SENSE_BOTH: set[t] = fin ^ st_ff.out_ff[t];
        default:     set[t] = 1'b0;
      endcase
    end
    access = apb_req.psel & apb_req.penable;
    idx = apb_req.paddr[7:2];
    ok = (apb_req.paddr[1:0] == 2'h0) && (idx < 6'(`REG_COUNT)) && (idx != `IDX_RSVD_A)
         && (idx != `IDX_RSVD_B) && (idx != `IDX_RSVD_C);
    nxt_st.pready_ff = access & ~st_ff.pready_ff;
    if (access && !st_ff.pready_ff) begin
      nxt_st.prdata_ff = ok ? 32'(st_ff.regs[idx]) : 32'h0000_0000;
      nxt_st.pslverr_ff = ~ok;
    end
    if (access && st_ff.pready_ff && apb_req.pwrite && ok) begin
      if (idx == `IDX_IRQ_FLAGS) begin
        nxt_st.regs[idx] = st_ff.regs[idx] & ~apb_req.pwdata[7:0];
      end else begin
        nxt_st.regs[idx] = apb_req.pwdata[7:0];
      end
    end
    // New events win over a clear in the same cycle
    nxt_st.regs[`IDX_IRQ_FLAGS][3:0] = nxt_st.regs[`IDX_IRQ_FLAGS][3:0] | set;
    nxt_st.irq_ff = |nxt_st.regs[`IDX_IRQ_FLAGS][3:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.regs <= {`REG_COUNT{`REG_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign table_out = st_ff.out_ff;
  assign irq = st_ff.irq_ff;
  assign apb_rsp = '{pready: st_ff.pready_ff, pslverr: st_ff.pslverr_ff,
                     prdata: st_ff.prdata_ff};

  // ==========================================================
  // Checks
  property p_irq_level;
    @(posedge core_clk) disable iff (reset)
    irq == (|st_ff.regs[`IDX_IRQ_FLAGS][3:0]);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not OR of flags");

  property p_flag_rise;
    @(posedge core_clk) disable iff (reset)
    ($rose(table_out[0]) && $past(st_ff.regs[`IDX_IRQ_CTRL][1:0]) == `SENSE_RISE)
      |-> st_ff.regs[`IDX_IRQ_FLAGS][0];
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("rise flag missing");

  property p_w1c;
    @(posedge core_clk) disable iff (reset)
    (apb_req.psel && apb_req.penable && st_ff.pready_ff && apb_req.pwrite
     && apb_req.paddr == 8'h1C && apb_req.pwdata[0] && !$rose(nxt_st.out_ff[0])
     && st_ff.regs[`IDX_IRQ_CTRL][1:0] == `SENSE_RISE)
      |=> !st_ff.regs[`IDX_IRQ_FLAGS][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_standby_zero;
    @(posedge core_clk) disable iff (reset)
    (stop && filt[1] != `FILT_OFF) |=> !table_out[1];
  endproperty
  a_standby_zero: assert property (p_standby_zero) else $error("output not forced");

  property p_jk_toggle;
    @(posedge core_clk) disable iff (reset)
    (enab[0] && st_ff.regs[`IDX_SEQ_CTRL0][3:0] == `SEQ_JK && tick[0] && post[0] && post[1])
      |=> st_ff.seq_ff[0] != $past(st_ff.seq_ff[0]);
  endproperty
  a_jk_toggle: assert property (p_jk_toggle) else $error("JK did not toggle");

  property p_dff_hold;
    @(posedge core_clk) disable iff (reset)
    (enab[0] && st_ff.regs[`IDX_SEQ_CTRL0][3:0] == `SEQ_DFF && !post[1])
      |=> $stable(st_ff.seq_ff[0]);
  endproperty
  a_dff_hold: assert property (p_dff_hold) else $error("DFF changed, gate low");

  property p_seq_clear;
    @(posedge core_clk) disable iff (reset)
    !enab[2] |=> !st_ff.seq_ff[1];
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("sequencer not cleared");

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  property p_apb_wait;
    @(posedge core_clk) disable iff (reset)
    s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready timing wrong");
endmodule // custom_logic_unit
`default_nettype wire

/* File: far_side.sv */
// Model of the pins, event channels and peripherals feeding the logic cell array
`default_nettype none
module far_side (
  input  wire logic            core_clk,
  input  wire logic [3:0]      ev_a_cmd,
  input  wire logic [3:0]      ev_b_cmd,
  input  wire logic [3:0][2:0] pin_cmd,
  output logic [3:0]           event_a,
  output logic [3:0]           event_b,
  output logic [3:0][2:0]      pin_in,
  output lut_pkg::periph_in_t  periph_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Idle levels before the first edge
  initial begin
    event_a   = '0;
    event_b   = '0;
    pin_in    = '0;
    periph_in = '0;
  end
  // ==========================================================
  // Commanded levels, launched just after the edge
  always @(posedge core_clk) begin
    event_a   <= ev_a_cmd;
    event_b   <= ev_b_cmd;
    pin_in    <= pin_cmd;
    // Busy peripherals: outputs count up by one every cycle
    periph_in <= lut_pkg::periph_in_t'(periph_in + 10'h001);
  end
endmodule // far_side
`default_nettype wire

/* File: custom_logic_unit_tb.sv */
// Self-checking bench of the logic cell array
`default_nettype none
`include "lut_cfg.svh"
module custom_logic_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                core_clk;
  logic                reset;
  lut_pkg::apb_req_t   apb_req;
  lut_pkg::apb_rsp_t   apb_rsp;
  logic [3:0]          event_a;
  logic [3:0]          event_b;
  logic [3:0][2:0]     pin_in;
  lut_pkg::periph_in_t periph_in;
  logic                standby_sleep;
  logic [3:0]          table_out;
  logic                irq;
  logic [3:0]          ev_a_cmd;
  logic [3:0]          ev_b_cmd;
  logic [3:0][2:0]     pin_cmd;
  logic                probe;
  logic [34:0]         exp_q[$];
  logic [34:0]         e;
  logic [7:0]          truth;
  logic [11:0]         steps;
  logic [2:0]          st;
  integer              seed;
  int                  error_cnt;
  int                  total_checks;

  custom_logic_unit uut (.core_clk(core_clk), .reset(reset), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .event_a(event_a), .event_b(event_b), .pin_in(pin_in),
    .periph_in(periph_in), .standby_sleep(standby_sleep), .table_out(table_out),
    .irq(irq));
  far_side partner (.core_clk(core_clk), .ev_a_cmd(ev_a_cmd), .ev_b_cmd(ev_b_cmd),
    .pin_cmd(pin_cmd), .event_a(event_a), .event_b(event_b), .pin_in(pin_in),
    .periph_in(periph_in));

  // ==========================================================
  // Reporting
  task automatic fail(input string msg);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers: one APB transfer, one output probe
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                     input logic err);
    int n;
    exp_q.push_back({wr, 1'b0, err, 24'h00_0000, d});
    @(posedge core_clk);
    apb_req <= {1'b1, 1'b0, wr, {idx, 2'b00}, {24'h00_0000, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    if (apb_rsp.pready !== 1'b1) begin
      fail("no ready");
      print_verdict();
    end else begin
      apb_req <= '0;
    end
  endtask
  task automatic look(input logic [4:0] exp);
    exp_q.push_back({2'b01, 1'b0, 27'h000_0000, exp});
    repeat (5) @(posedge core_clk);
    probe <= 1'b1;
    @(posedge core_clk);
    probe <= 1'b0;
  endtask

  // ==========================================================
  // Monitor: oldest note against each result
  always @(negedge core_clk) begin
    if (apb_rsp.pready === 1'b1 || probe === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        fail("unexpected result");
      end else begin
        e = exp_q.pop_front();
        if (e[34]) begin
          if (apb_rsp.pslverr !== e[32]) fail("write response");
        end else if (e[33]) begin
          if ({table_out, irq} !== e[4:0]) fail("table outputs");
        end else if ({apb_rsp.pslverr, apb_rsp.prdata} !== e[32:0]) begin
          fail("read response");
        end
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    fail("timeout");
    print_verdict();
  end

  initial begin
    seed          = 32'h059a_3a0f;
    reset         = 1'b1;
    apb_req       = '0;
    standby_sleep = 1'b0;
    ev_a_cmd      = '0;
    ev_b_cmd      = '0;
    pin_cmd       = '0;
    probe         = 1'b0;
    error_cnt     = 0;
    total_checks  = 0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // ==========================================================
    // Reset values, unmapped places, read back
    apb(1'b0, 6'h00, 8'h00, 1'b0);
    apb(1'b0, 6'h0b, 8'h00, 1'b0);
    apb(1'b1, 6'h03, 8'h5a, 1'b1);
    apb(1'b0, 6'h03, 8'h00, 1'b1);
    apb(1'b0, 6'h18, 8'h00, 1'b1);
    apb(1'b1, 6'h00, 8'h01, 1'b0);
    apb(1'b0, 6'h00, 8'h01, 1'b0);
    // ==========================================================
    // Truth decode over all input combinations
    apb(1'b1, 6'h08, 8'h01, 1'b0);
    apb(1'b1, 6'h09, 8'h43, 1'b0);
    apb(1'b1, 6'h0a, 8'h05, 1'b0);
    repeat (4) begin
      truth = 8'($random(seed));
      apb(1'b1, 6'h0b, truth, 1'b0);
      for (int i = 0; i < 8; i++) begin
        ev_a_cmd[0]   <= i[0];
        ev_b_cmd[0]   <= i[1];
        pin_cmd[0][2] <= i[2];
        look({3'b000, truth[i], 1'b0});
      end
    end
    // ==========================================================
    // Interrupt sense codes, flags and request
    ev_a_cmd <= '0;
    ev_b_cmd <= '0;
    pin_cmd  <= '0;
    apb(1'b1, 6'h0b, 8'haa, 1'b0);
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, `IDX_IRQ_CTRL, {6'h00, 2'(m)}, 1'b0);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h0f, 1'b0);
      ev_a_cmd[0] <= 1'b1;
      look({4'b0001, m[0]});
      apb(1'b0, `IDX_IRQ_FLAGS, {7'h00, m[0]}, 1'b0);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h00, 1'b0);
      apb(1'b0, `IDX_IRQ_FLAGS, {7'h00, m[0]}, 1'b0);
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h01, 1'b0);
      ev_a_cmd[0] <= 1'b0;
      look({4'b0000, m[1]});
      apb(1'b1, `IDX_IRQ_FLAGS, 8'h0f, 1'b0);
      look(5'b00000);
    end
    apb(1'b1, `IDX_IRQ_CTRL, 8'h00, 1'b0);
    // ==========================================================
    // Sequencer modes: steps of {even, odd, expected output}
    apb(1'b1, 6'h0c, 8'h01, 1'b0);
    apb(1'b1, 6'h0d, 8'h03, 1'b0);
    apb(1'b1, 6'h0f, 8'haa, 1'b0);
    for (int m = 1; m < 5; m++) begin
      steps = m[0] ? 12'he54 : 12'ha50;
      apb(1'b1, `IDX_SEQ_CTRL0, 8'(m), 1'b0);
      for (int s = 3; s >= 0; s--) begin
        st = steps[s*3 +: 3];
        ev_a_cmd[1:0] <= {st[1], st[2]};
        look({2'b00, st[1], st[0], 1'b0});
      end
    end
    // ==========================================================
    // Single toggle, standby forcing, clear on disable
    apb(1'b1, `IDX_SEQ_CTRL0, 8'h02, 1'b0);
    ev_a_cmd[1:0] <= 2'b11;
    @(posedge core_clk);
    ev_a_cmd[1:0] <= 2'b00;
    look(5'b00010);
    apb(1'b1, 6'h00, 8'h41, 1'b0);
    standby_sleep <= 1'b1;
    look(5'b00010);
    apb(1'b1, 6'h00, 8'h01, 1'b0);
    look(5'b00000);
    standby_sleep <= 1'b0;
    apb(1'b1, 6'h08, 8'h00, 1'b0);
    apb(1'b1, 6'h08, 8'h01, 1'b0);
    look(5'b00000);
    // ==========================================================
    // Filter, edge detect with sync, alternate clock
    apb(1'b1, 6'h10, 8'h21, 1'b0);
    apb(1'b1, 6'h11, 8'h03, 1'b0);
    apb(1'b1, 6'h13, 8'haa, 1'b0);
    ev_a_cmd[2] <= 1'b1;
    repeat (4) @(posedge core_clk);
    look(5'b01000);
    apb(1'b1, 6'h10, 8'h91, 1'b0);
    look(5'b00000);
    apb(1'b1, 6'h00, 8'h00, 1'b0);
    apb(1'b1, 6'h10, 8'h03, 1'b0);
    apb(1'b1, 6'h00, 8'h01, 1'b0);
    look(5'b01000);
    print_verdict();
  end
endmodule // custom_logic_unit_tb
`default_nettype wire
